// ==== hdl/dam_pkg.sv ====
package dam_pkg;
    // ==========================================================
    // register offsets
    localparam logic [15:0] OFF_LINK_CTRL   = 16'h0120;
    localparam logic [15:0] OFF_LINK_STATE  = 16'h0134;
    localparam logic [15:0] OFF_GENERIC     = 16'h1001;
    localparam logic [15:0] OFF_ALARM_CLR   = 16'h2057;
    localparam logic [15:0] OFF_HISTORY     = 16'h3FFE;
    localparam logic [15:0] OFF_PROFILE     = 16'h603F;
    localparam logic [15:0] OFF_CONTROLWORD = 16'h6040;
    localparam int          CW_CLR_BIT      = 7;
    localparam int          LC_ACK_BIT      = 4;
    localparam logic [15:0] CLR_VALUE       = 16'h0001;
    // ==========================================================
    // drive fault indices
    localparam int NDRV   = 6;
    localparam int F_OC   = 0;
    localparam int F_AMPA = 1;
    localparam int F_AMPB = 2;
    localparam int F_OV   = 3;
    localparam int F_VEL  = 4;
    localparam int F_SAVE = 5;
    typedef logic [15:0] dam_w_t;
    typedef logic [7:0]  dam_b_t;
    localparam dam_w_t DRV_HIST [NDRV] = '{16'h00E0, 16'h00A0, 16'h00A1,
                                          16'h00C0, 16'h01A0, 16'h0240};
    localparam dam_b_t DRV_GEN  [NDRV] = '{8'h02, 8'h04, 8'h04, 8'h04, 8'h20, 8'h80};
    localparam dam_w_t DRV_PROF [NDRV] = '{16'h2211, 16'h3150, 16'h3151,
                                          16'h3211, 16'h8402, 16'h5530};
    localparam logic [3:0] DRV_FLASH [NDRV] = '{4'h1, 4'hC, 4'hC, 4'h2, 4'h5, 4'h8};
    localparam logic [NDRV-1:0] DRV_CLEARABLE = 6'h38;
    // ==========================================================
    // comm fault indices
    localparam int NCOM     = 6;
    localparam int C_WDTO   = 0;
    localparam int C_SYNCIO = 1;
    localparam int C_BADTR  = 2;
    localparam int C_UNKTR  = 3;
    localparam int C_WDCFG  = 4;
    localparam int C_BOOT   = 5;
    localparam dam_b_t COM_GEN = 8'h10;
    localparam dam_w_t COM_PROF [NCOM] = '{16'h821B, 16'h8733, 16'hA001,
                                          16'hA002, 16'h821F, 16'h8213};
    localparam dam_w_t COM_HIST [NCOM] = '{16'h001B, 16'h0033, 16'h0011,
                                          16'h0012, 16'h0000, 16'h0000};
    localparam logic [NCOM-1:0] COM_SAVED = 6'h0F;
    // led pattern kinds
    typedef enum {PAT_SINGLE, PAT_DOUBLE, PAT_BLINK, PAT_FLICKER} dam_pat_e;
    localparam dam_pat_e COM_PAT [NCOM] = '{PAT_DOUBLE, PAT_SINGLE, PAT_BLINK,
                                           PAT_BLINK, PAT_BLINK, PAT_FLICKER};
    // ==========================================================
    // timing
    localparam int CLK_MHZ     = 125;
    localparam int FLICKER_NS  = 50_000_000;
    localparam int BLINK_NS    = 200_000_000;
    localparam int FLASH_NS    = 200_000_000;
    localparam int PAUSE_NS    = 1_000_000_000;
    localparam int FLICKER_CYC = FLICKER_NS / 1000 * CLK_MHZ / 1000;
    localparam int BLINK_CYC   = BLINK_NS / 1000 * CLK_MHZ / 1000;
    localparam int FLASH_CYC   = FLASH_NS / 1000 * CLK_MHZ / 1000;
    localparam int PAUSE_CYC   = PAUSE_NS / 1000 * CLK_MHZ / 1000;
    // object write bus
    typedef struct packed {
        logic   wr;
        dam_w_t addr;
        dam_w_t data;
    } dam_wr_s;
endpackage

// ==== hdl/dam_alarm_manager.sv ====
`timescale 1ns/10ps
module dam_alarm_manager #(
    parameter int FLASH_CYC   = dam_pkg::FLASH_CYC,   // flash half period
    parameter int PAUSE_CYC   = dam_pkg::PAUSE_CYC,   // dark pause between groups
    parameter int BLINK_CYC   = dam_pkg::BLINK_CYC,   // blinking half period
    parameter int FLICKER_CYC = dam_pkg::FLICKER_CYC  // flickering half period
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire dam_pkg::dam_wr_s            objWr,         // object / register write
    input  wire logic [15:0]                 rdAddr,        // read address
    output logic [15:0]                      rdData,        // read data
    input  wire logic [dam_pkg::NDRV-1:0]    driveFault,    // drive fault causes, level
    input  wire logic [dam_pkg::NCOM-1:0]    commFault,     // comm fault events, pulse
    output logic                             motorEnable,   // motor drive allowed
    output logic                             powerAlarmLed, // red alarm led
    output logic                             commIndicatorLed, // red comm led
    output logic                             profileFault   // profile state in fault
);
    // ==========================================================
    // state
    logic [dam_pkg::NDRV-1:0] drvAct_ff;      // latched drive alarms
    logic [dam_pkg::NCOM-1:0] comAct_ff;      // latched comm alarms
    logic [15:0]              hist_ff;        // history alarm object
    logic [7:0]               gen_ff;         // generic error object
    logic [15:0]              prof_ff;        // profile error object
    logic                     cwBit_ff;       // previous controlword bit 7
    logic                     fault_ff;       // profile fault state
    logic [15:0]              linkCtrl_ff;    // link control register
    logic                     clrDrv;         // drive clear request
    logic                     ackCom;         // comm acknowledge
    logic                     cwRise;         // controlword bit 7 rising
    logic [dam_pkg::NDRV-1:0] drvSet;         // new drive alarms
    logic [dam_pkg::NCOM-1:0] comSet;         // new comm alarms

    // ==========================================================
    // clear requests
    assign cwRise = objWr.wr && objWr.addr == dam_pkg::OFF_CONTROLWORD
                    && objWr.data[dam_pkg::CW_CLR_BIT] && !cwBit_ff;
    assign clrDrv = (objWr.wr && objWr.addr == dam_pkg::OFF_ALARM_CLR
                     && objWr.data == dam_pkg::CLR_VALUE) || cwRise;
    assign ackCom = objWr.wr && objWr.addr == dam_pkg::OFF_LINK_CTRL
                    && objWr.data[dam_pkg::LC_ACK_BIT];
    assign drvSet = driveFault & ~drvAct_ff;
    assign comSet = commFault;

    // registered controlword bit 7
    always_ff @(posedge clk) begin
        if (rst) begin
            cwBit_ff <= 1'b0;
        end else if (objWr.wr && objWr.addr == dam_pkg::OFF_CONTROLWORD) begin
            cwBit_ff <= objWr.data[dam_pkg::CW_CLR_BIT];
        end
    end

    // link control register store
    always_ff @(posedge clk) begin
        if (rst) begin
            linkCtrl_ff <= 16'h0000;
        end else if (objWr.wr && objWr.addr == dam_pkg::OFF_LINK_CTRL) begin
            linkCtrl_ff <= objWr.data;
        end
    end

    // ==========================================================
    // alarm latches; set wins over clear, cleared only if cause gone
    always_ff @(posedge clk) begin
        if (rst) begin
            drvAct_ff <= '0;
        end else begin
            for (int i = 0; i < dam_pkg::NDRV; i++) begin
                if (driveFault[i]) begin
                    drvAct_ff[i] <= 1'b1;
                end else if (clrDrv && dam_pkg::DRV_CLEARABLE[i]) begin
                    drvAct_ff[i] <= 1'b0;
                end
            end
        end
    end

    // comm alarms, acknowledged by link control bit 4
    always_ff @(posedge clk) begin
        if (rst) begin
            comAct_ff <= '0;
        end else begin
            comAct_ff <= comSet | (ackCom ? '0 : comAct_ff);
        end
    end

    // ==========================================================
    // error objects; every new fault updates generic and profile, history only for drive faults and COM_SAVED comm faults
    always_ff @(posedge clk) begin
        if (rst) begin
            hist_ff <= 16'h0000;
            gen_ff  <= 8'h00;
            prof_ff <= 16'h0000;
        end else begin
            if (clrDrv && !(|driveFault) && !(|comAct_ff)) begin
                gen_ff  <= 8'h00;
                prof_ff <= 16'h0000;
            end
            for (int i = 0; i < dam_pkg::NDRV; i++) begin
                if (drvSet[i]) begin
                    hist_ff <= dam_pkg::DRV_HIST[i];
                    gen_ff  <= dam_pkg::DRV_GEN[i];
                    prof_ff <= dam_pkg::DRV_PROF[i];
                end
            end
            for (int j = 0; j < dam_pkg::NCOM; j++) begin
                if (comSet[j]) begin
                    gen_ff  <= dam_pkg::COM_GEN;
                    prof_ff <= dam_pkg::COM_PROF[j];
                    if (dam_pkg::COM_SAVED[j]) begin
                        hist_ff <= dam_pkg::COM_HIST[j];
                    end
                end
            end
        end
    end

    // profile fault state machine flag
    always_ff @(posedge clk) begin
        if (rst) begin
            fault_ff <= 1'b0;
        end else if (|drvSet || |comSet) begin
            fault_ff <= 1'b1;
        end else if (cwRise) begin
            fault_ff <= 1'b0;
        end
    end
    assign profileFault = fault_ff;
    assign motorEnable  = !(|drvAct_ff);

    // ==========================================================
    // read mux
    always_ff @(posedge clk) begin
        if (rst) begin
            rdData <= 16'h0000;
        end else begin
            case (rdAddr)
                dam_pkg::OFF_LINK_CTRL:  rdData <= linkCtrl_ff;
                dam_pkg::OFF_LINK_STATE: rdData <= {{(16-dam_pkg::NCOM){1'b0}},
                                                    comAct_ff};
                dam_pkg::OFF_GENERIC:    rdData <= {8'h00, gen_ff};
                dam_pkg::OFF_HISTORY:    rdData <= hist_ff;
                dam_pkg::OFF_PROFILE:    rdData <= prof_ff;
                default:                 rdData <= 16'h0000;
            endcase
        end
    end

    // ==========================================================
    // alarm led flash groups: first active fault picks the count
    typedef enum {FL_OFF, FL_ON, FL_GAP, FL_PAUSE} dam_fl_e;
    dam_fl_e     flSt_ff;          // flash state
    logic [31:0] flTmr_ff;         // flash timer
    logic [3:0]  flCnt_ff;         // flashes done
    logic [3:0]  flTarget;         // flashes wanted
    logic        aLed_ff;          // alarm led register

    always_comb begin
        flTarget = 4'h0;
        for (int i = dam_pkg::NDRV - 1; i >= 0; i--) begin
            if (drvAct_ff[i]) begin
                flTarget = dam_pkg::DRV_FLASH[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flSt_ff  <= FL_OFF;
            flTmr_ff <= '0;
            flCnt_ff <= 4'h0;
            aLed_ff  <= 1'b0;
        end else begin
            case (flSt_ff)
                FL_OFF: begin
                    aLed_ff  <= 1'b0;
                    flCnt_ff <= 4'h0;
                    flTmr_ff <= '0;
                    if (flTarget != 4'h0) begin
                        flSt_ff <= FL_ON;
                        aLed_ff <= 1'b1;
                    end
                end
                FL_ON: begin
                    flTmr_ff <= flTmr_ff + 32'h1;
                    if (flTmr_ff >= 32'(FLASH_CYC - 1)) begin
                        flTmr_ff <= '0;
                        aLed_ff  <= 1'b0;
                        flCnt_ff <= flCnt_ff + 4'h1;
                        flSt_ff  <= (flCnt_ff + 4'h1 >= flTarget) ? FL_PAUSE : FL_GAP;
                    end
                end
                FL_GAP: begin
                    flTmr_ff <= flTmr_ff + 32'h1;
                    if (flTmr_ff >= 32'(FLASH_CYC - 1)) begin
                        flTmr_ff <= '0;
                        aLed_ff  <= 1'b1;
                        flSt_ff  <= FL_ON;
                    end
                end
                FL_PAUSE: begin
                    flTmr_ff <= flTmr_ff + 32'h1;
                    if (flTmr_ff >= 32'(PAUSE_CYC - 1)) begin
                        flSt_ff <= FL_OFF;
                    end
                end
                default: flSt_ff <= FL_OFF;
            endcase
        end
    end
    assign powerAlarmLed = aLed_ff;

    // ==========================================================
    // comm led: pattern of highest-priority active comm fault
    dam_pkg::dam_pat_e comPat;     // selected pattern
    logic [31:0]       cTmr_ff;    // comm timer
    logic [2:0]        cPh_ff;     // phase in a cycle of eight
    logic              cLed_ff;    // comm led register
    logic [31:0]       cHalf;      // step length

    always_comb begin
        comPat = dam_pkg::PAT_BLINK;
        for (int j = dam_pkg::NCOM - 1; j >= 0; j--) begin
            if (comAct_ff[j]) begin
                comPat = dam_pkg::COM_PAT[j];
            end
        end
        cHalf = (comPat == dam_pkg::PAT_FLICKER) ? 32'(FLICKER_CYC) : 32'(BLINK_CYC);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cTmr_ff <= '0;
            cPh_ff  <= 3'h0;
            cLed_ff <= 1'b0;
        end else if (!(|comAct_ff)) begin
            cTmr_ff <= '0;
            cPh_ff  <= 3'h0;
            cLed_ff <= 1'b0;
        end else begin
            cTmr_ff <= cTmr_ff + 32'h1;
            if (cTmr_ff >= cHalf - 32'h1) begin
                cTmr_ff <= '0;
                cPh_ff  <= cPh_ff + 3'h1;
            end
            case (comPat)
                dam_pkg::PAT_SINGLE: cLed_ff <= (cPh_ff == 3'h0);
                dam_pkg::PAT_DOUBLE: cLed_ff <= (cPh_ff == 3'h0) || (cPh_ff == 3'h2);
                default:             cLed_ff <= cPh_ff[0];
            endcase
        end
    end
    assign commIndicatorLed = cLed_ff;

    // ==========================================================
    // checks
    chk_motor_stop: assert property (@(posedge clk) disable iff (rst)
        |driveFault |=> !motorEnable) else $error("motor not stopped");
    chk_hard_hold: assert property (@(posedge clk) disable iff (rst)
        drvAct_ff[dam_pkg::F_OC] |=> drvAct_ff[dam_pkg::F_OC])
        else $error("over current cleared");
    chk_oc_codes: assert property (@(posedge clk) disable iff (rst)
        drvSet == 6'h01 && commFault == '0 |=> hist_ff == 16'h00E0 && prof_ff == 16'h2211)
        else $error("over current codes wrong");
    chk_clear_soft: assert property (@(posedge clk) disable iff (rst)
        clrDrv && driveFault == '0 |=> (drvAct_ff & 6'h38) == '0)
        else $error("soft alarm not cleared");
    chk_cw_edge: assert property (@(posedge clk) disable iff (rst)
        cwRise && !(|drvSet) && !(|comSet) |=> !profileFault)
        else $error("fault state not left");
    chk_wd_codes: assert property (@(posedge clk) disable iff (rst)
        commFault == 6'h01 && drvSet == '0 |=> prof_ff == 16'h821B
        && gen_ff == 8'h10 && hist_ff == 16'h001B)
        else $error("watchdog codes wrong");
    chk_boot_nohist: assert property (@(posedge clk) disable iff (rst)
        commFault == 6'h20 && drvSet == '0 |=> hist_ff == $past(hist_ff))
        else $error("boot fault stored");
    // ==========================================================
    // per-fault code checks

    // over voltage codes
    chk_ov_codes: assert property (@(posedge clk) disable iff (rst)
        drvSet == 6'h08 && commFault == '0 |=> hist_ff == 16'h00C0
        && gen_ff == 8'h04 && prof_ff == 16'h3211) else $error("over voltage codes wrong");

    // excess velocity codes
    chk_vel_codes: assert property (@(posedge clk) disable iff (rst)
        drvSet == 6'h10 && commFault == '0 |=> hist_ff == 16'h01A0
        && gen_ff == 8'h20 && prof_ff == 16'h8402) else $error("velocity codes wrong");

    // save failure codes
    chk_save_codes: assert property (@(posedge clk) disable iff (rst)
        drvSet == 6'h20 && commFault == '0 |=> hist_ff == 16'h0240
        && gen_ff == 8'h80 && prof_ff == 16'h5530) else $error("save codes wrong");

    // phase A amplifier codes
    chk_ampa_codes: assert property (@(posedge clk) disable iff (rst)
        drvSet == 6'h02 && commFault == '0 |=> hist_ff == 16'h00A0
        && gen_ff == 8'h04 && prof_ff == 16'h3150) else $error("phase A codes wrong");

    // phase B amplifier codes
    chk_ampb_codes: assert property (@(posedge clk) disable iff (rst)
        drvSet == 6'h04 && commFault == '0 |=> hist_ff == 16'h00A1
        && gen_ff == 8'h04 && prof_ff == 16'h3151) else $error("phase B codes wrong");

    // phase A alarm survives any clear
    chk_ampa_hold: assert property (@(posedge clk) disable iff (rst)
        drvAct_ff[dam_pkg::F_AMPA] |=> drvAct_ff[dam_pkg::F_AMPA])
        else $error("phase A cleared");

    // phase B alarm survives any clear
    chk_ampb_hold: assert property (@(posedge clk) disable iff (rst)
        drvAct_ff[dam_pkg::F_AMPB] |=> drvAct_ff[dam_pkg::F_AMPB])
        else $error("phase B cleared");

    // sync io error codes
    chk_sync_codes: assert property (@(posedge clk) disable iff (rst)
        commFault == 6'h02 && drvSet == '0 |=> prof_ff == 16'h8733
        && hist_ff == 16'h0033) else $error("sync io codes wrong");

    // invalid transition codes
    chk_badtr_codes: assert property (@(posedge clk) disable iff (rst)
        commFault == 6'h04 && drvSet == '0 |=> prof_ff == 16'hA001
        && hist_ff == 16'h0011) else $error("invalid transition codes wrong");

    // unknown transition codes
    chk_unktr_codes: assert property (@(posedge clk) disable iff (rst)
        commFault == 6'h08 && drvSet == '0 |=> prof_ff == 16'hA002
        && hist_ff == 16'h0012) else $error("unknown transition codes wrong");

    // watchdog config kept out of history
    chk_wdcfg_nohist: assert property (@(posedge clk) disable iff (rst)
        commFault == 6'h10 && drvSet == '0 |=> prof_ff == 16'h821F
        && hist_ff == $past(hist_ff)) else $error("watchdog config stored");

    // any comm fault sets generic code
    chk_comm_generic: assert property (@(posedge clk) disable iff (rst)
        |commFault && drvSet == '0 |=> gen_ff == 8'h10)
        else $error("comm generic code wrong");

    // ==========================================================
    // led and read checks

    // comm led dark with no comm alarm
    chk_led_quiet: assert property (@(posedge clk) disable iff (rst)
        comAct_ff == '0 |=> !commIndicatorLed) else $error("comm led lit");

    // link state read shows alarm bitmap
    chk_link_read: assert property (@(posedge clk) disable iff (rst)
        rdAddr == dam_pkg::OFF_LINK_STATE |=> rdData == 16'($past(comAct_ff)))
        else $error("link state read wrong");

    // flash count never passes twelve
    chk_cnt_bound: assert property (@(posedge clk) disable iff (rst)
        flCnt_ff <= 4'hC) else $error("flash count overrun");

    // idle flasher with a fault pending
    sequence seqFlashIdle;
        flSt_ff == FL_OFF && flTarget != 4'h0;
    endsequence

    // group opens with the led lit
    sequence seqFlashOpen;
        powerAlarmLed && flSt_ff == FL_ON;
    endsequence

    // flasher starts a group at once
    chk_flash_start: assert property (@(posedge clk) disable iff (rst)
        seqFlashIdle |=> seqFlashOpen) else $error("flash group not started");

    // alarm led dark with no drive alarm
    chk_alarm_dark: assert property (@(posedge clk) disable iff (rst)
        drvAct_ff == '0 && flSt_ff == FL_OFF |=> !powerAlarmLed)
        else $error("alarm led lit");

    chk_ack_release: assert property (@(posedge clk) disable iff (rst)
        ackCom && commFault == '0 |=> comAct_ff == '0 ##2 !commIndicatorLed)
        else $error("comm alarm not released");
endmodule

// ==== test/dam_master_model.sv ====
`timescale 1ns/10ps
// ==========================================================
// fieldbus master: one-cycle object writes to the drive
module dam_master_model (
    input  wire logic        clk,
    output dam_pkg::dam_wr_s objWr
);
    // idle bus at time zero
    initial begin
        objWr = '0;
    end
    // strobe high for one edge, then address and data inverted
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        objWr <= '{1'h1, a, d};
        @(posedge clk);
        objWr <= '{1'h0, ~a, ~d};
    endtask
    // alarm clear object gets value one
    task automatic clrAlarm();
        wr(dam_pkg::OFF_ALARM_CLR, dam_pkg::CLR_VALUE);
    endtask
    // error-state acknowledge in link control
    task automatic ackComm();
        wr(dam_pkg::OFF_LINK_CTRL, 16'h0010);
    endtask
    // controlword bit 7 low then high
    task automatic cwRise();
        wr(dam_pkg::OFF_CONTROLWORD, 16'h0000);
        wr(dam_pkg::OFF_CONTROLWORD, 16'h0080);
    endtask
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
// ==========================================================
// bench for the alarm manager
module tb_top;
    localparam int FL  = 4;          // shortened flash half period
    localparam int GAP = 2 * FL + 2; // dark run that marks a group pause
    logic             clk;
    logic             rst;
    dam_pkg::dam_wr_s objWr;         // from master model
    logic [15:0]      rdAddr;
    logic [15:0]      rdData;
    logic [15:0]      expHist;       // history expected so far
    logic [5:0]       driveFault;
    logic [5:0]       commFault;
    logic             motorEnable;
    logic             powerAlarmLed;
    logic             commIndicatorLed;
    logic             profileFault;
    int               numErrors = 0;
    int               numChecks = 0;
    int               cycles    = 0;
    int               n;
    dam_alarm_manager #(.FLASH_CYC(FL), .PAUSE_CYC(24), .BLINK_CYC(4), .FLICKER_CYC(2)) dut_u (
        .clk(clk), .rst(rst), .objWr(objWr), .rdAddr(rdAddr), .rdData(rdData),
        .driveFault(driveFault), .commFault(commFault), .motorEnable(motorEnable),
        .powerAlarmLed(powerAlarmLed), .commIndicatorLed(commIndicatorLed),
        .profileFault(profileFault));
    dam_master_model mstr_u (.clk(clk), .objWr(objWr));
    // ==========================================================
    // clock and hang guard
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            $display("mismatch %0t run too long", $time);
            numErrors = numErrors + 1;
            endSim();
        end
    end
    // ==========================================================
    // helpers
    task automatic endSim();
        $display("checks %0d mismatches %0d", numChecks, numErrors);
        if (numErrors == 0 && numChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        numChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // let two edges land, sample 1 ns after the second
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    // registered read, data one cycle after address
    task automatic rdChk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk);
        rdAddr <= a;
        @(posedge clk);
        #1;
        chk(rdData, exp, $sformatf("read %h", a));
    endtask
    task automatic doReset();
        @(posedge clk);
        rst <= 1'h1;
        @(posedge clk);
        rst <= 1'h0;
        settle();
    endtask
    // wait for a group pause, then count flashes of one group
    task automatic flashes(output int cnt);
        int   gap;
        logic prev;
        gap = 0;
        cnt = 0;
        prev = 1'h0;
        while (gap < GAP) begin
            @(posedge clk);
            #1;
            gap = powerAlarmLed ? 0 : gap + 1;
        end
        gap = 0;
        while (gap < GAP) begin
            @(posedge clk);
            #1;
            if (powerAlarmLed && !prev) cnt++;
            gap = (cnt == 0 || powerAlarmLed) ? 0 : gap + 1;
            prev = powerAlarmLed;
        end
    endtask
    // ==========================================================
    // main sequence
    initial begin
        rst = 1'h1;
        rdAddr = 16'h0000;
        driveFault = 6'h00;
        commFault = 6'h00;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        settle();
        chk(motorEnable, 1'h1, "motor after reset");
        chk({powerAlarmLed, commIndicatorLed, profileFault}, 3'h0, "outputs after reset");
        rdChk(dam_pkg::OFF_LINK_STATE, 16'h0000);
        rdChk(dam_pkg::OFF_GENERIC, 16'h0000);
        rdChk(dam_pkg::OFF_HISTORY, 16'h0000);
        rdChk(dam_pkg::OFF_PROFILE, 16'h0000);
        $display("test reset done");
        // clearable drive faults, clear refused then accepted
        for (int i = dam_pkg::F_OV; i <= dam_pkg::F_SAVE; i++) begin
            @(posedge clk);
            driveFault[i] <= 1'h1;
            settle();
            chk(motorEnable, 1'h0, "motor stop");
            chk(profileFault, 1'h1, "profile fault");
            rdChk(dam_pkg::OFF_HISTORY, dam_pkg::DRV_HIST[i]);
            rdChk(dam_pkg::OFF_GENERIC, {8'h00, dam_pkg::DRV_GEN[i]});
            rdChk(dam_pkg::OFF_PROFILE, dam_pkg::DRV_PROF[i]);
            flashes(n);
            chk(16'(n), {12'h000, dam_pkg::DRV_FLASH[i]}, "flash count");
            mstr_u.clrAlarm();
            settle();
            chk(motorEnable, 1'h0, "cause still present");
            @(posedge clk);
            driveFault[i] <= 1'h0;
            mstr_u.wr(dam_pkg::OFF_ALARM_CLR, 16'h0002);
            settle();
            chk(motorEnable, 1'h0, "clear value two");
            mstr_u.wr(dam_pkg::OFF_CONTROLWORD, 16'h0080);
            settle();
            chk(profileFault, i == dam_pkg::F_OV ? 1'h0 : 1'h1, "bit7 held");
            mstr_u.cwRise();
            settle();
            chk(profileFault, 1'h0, "bit7 rise");
            mstr_u.clrAlarm();
            settle();
            chk(motorEnable, 1'h1, "alarm cleared");
            rdChk(dam_pkg::OFF_GENERIC, 16'h0000);
        end
        $display("test clearable done");
        // two faults at once, lowest index shown, the one whose cause stays is held
        @(posedge clk);
        driveFault <= 6'h18;
        flashes(n);
        chk(16'(n), 16'h0002, "joint flash count");
        @(posedge clk);
        driveFault <= 6'h10;
        mstr_u.clrAlarm();
        settle();
        chk(motorEnable, 1'h0, "second fault kept");
        @(posedge clk);
        driveFault <= 6'h00;
        mstr_u.clrAlarm();
        settle();
        chk(motorEnable, 1'h1, "both cleared");
        $display("test joint done");
        // hard faults survive clear, only reset removes them
        for (int i = dam_pkg::F_OC; i <= dam_pkg::F_AMPB; i++) begin
            @(posedge clk);
            driveFault[i] <= 1'h1;
            settle();
            chk(motorEnable, 1'h0, "motor stop hard");
            rdChk(dam_pkg::OFF_HISTORY, dam_pkg::DRV_HIST[i]);
            rdChk(dam_pkg::OFF_GENERIC, {8'h00, dam_pkg::DRV_GEN[i]});
            rdChk(dam_pkg::OFF_PROFILE, dam_pkg::DRV_PROF[i]);
            flashes(n);
            chk(16'(n), {12'h000, dam_pkg::DRV_FLASH[i]}, "hard flash count");
            @(posedge clk);
            driveFault[i] <= 1'h0;
            mstr_u.clrAlarm();
            settle();
            chk(motorEnable, 1'h0, "hard fault kept");
            doReset();
            chk(motorEnable, 1'h1, "hard fault reset");
        end
        $display("test hard done");
        // comm faults: codes, history, led, acknowledge
        expHist = 16'h0000;
        for (int i = 0; i < dam_pkg::NCOM; i++) begin
            @(posedge clk);
            commFault[i] <= 1'h1;
            @(posedge clk);
            commFault[i] <= 1'h0;
            settle();
            if (dam_pkg::COM_SAVED[i]) expHist = dam_pkg::COM_HIST[i];
            rdChk(dam_pkg::OFF_PROFILE, dam_pkg::COM_PROF[i]);
            rdChk(dam_pkg::OFF_GENERIC, {8'h00, dam_pkg::COM_GEN});
            rdChk(dam_pkg::OFF_HISTORY, expHist);
            rdChk(dam_pkg::OFF_LINK_STATE, 16'h0001 << i);
            n = 0;
            while (n < 100 && commIndicatorLed !== 1'h1) begin
                @(posedge clk);
                #1;
                n++;
            end
            chk(commIndicatorLed, 1'h1, "comm led on");
            mstr_u.ackComm();
            settle();
            rdChk(dam_pkg::OFF_LINK_STATE, 16'h0000);
            chk(commIndicatorLed, 1'h0, "comm led off");
            rdChk(dam_pkg::OFF_LINK_CTRL, 16'h0010);
        end
        $display("test comm done");
        endSim();
    end
endmodule
